/* shared/ocdst_pkg.sv */
// Constants and types for the opcode decode and state accounting block.
// Assumes a single sys_clk domain and an asynchronous active-low reset.
package ocdst_pkg;
	localparam int OP_HI_BIT    = 15;
	localparam int OP_LO_BIT    = 8;
	localparam int SEL_BIT      = 7;
	localparam int CNT_W        = 8;
	localparam int STATE_W      = 12;
	localparam logic [1:0] S_MEM_ACCESS = 2'h2;
	localparam logic [1:0] S_INTERNAL   = 2'h1;
	localparam logic [1:0] S_PERIPH_FAST = 2'h2;
	localparam logic [1:0] S_PERIPH_SLOW = 2'h3;
	localparam logic [7:0]  OP_RESET     = 8'h00;
	localparam logic        SEL_RESET    = 1'b0;
	localparam logic [STATE_W-1:0] STATES_RESET = 12'h000;

	typedef enum logic [4:0] {
		OCD_NOP, OCD_SLEEP, OCD_CTRL_REG, OCD_ADD, OCD_ADDX, OCD_SUB, OCD_SUBX,
		OCD_CMP, OCD_INCDEC, OCD_ADJ, OCD_SHIFT, OCD_ROTATE, OCD_LOGIC,
		OCD_UNARY, OCD_BRANCH, OCD_MULDIV, OCD_RETURN, OCD_CALL, OCD_JUMP,
		OCD_BIT, OCD_BLOCK_MOVE, OCD_DATA_TRANSFER_OP, OCD_UNDEF
	} ocdst_class_t;

	localparam ocdst_class_t CLASS_RESET = OCD_NOP;
endpackage

/* rtl/ocdst_state_sum.sv */
// Weighted sum of cycle counts into execution states.
// Assumes counts are stable for the cycle they are presented.
module ocdst_state_sum
	import ocdst_pkg::*;
#(
	parameter int CW = ocdst_pkg::CNT_W,
	parameter int SW = ocdst_pkg::STATE_W
) (
	input  wire logic [CW-1:0] cnt_fetch,
	input  wire logic [CW-1:0] cnt_branch,
	input  wire logic [CW-1:0] cnt_stack,
	input  wire logic [CW-1:0] cnt_byte,
	input  wire logic [CW-1:0] cnt_word,
	input  wire logic [CW-1:0] cnt_internal,
	input  wire logic          byte_periph,
	input  wire logic          periph_slow,
	output logic      [SW-1:0] states
);
	// Full-scale counts at costs summing to twelve need four extra bits
	if (SW < CW + 4) begin : g_width_chk
		$error("state width too small");
	end
	logic [1:0]    s_byte;
	logic [SW-1:0] sum;
	assign s_byte = byte_periph ? (periph_slow ? S_PERIPH_SLOW : S_PERIPH_FAST)
	                            : S_MEM_ACCESS;
	// weighted state sum; memory and internal costs
	always_comb begin
		sum = SW'(cnt_fetch) * SW'(S_MEM_ACCESS)
		    + SW'(cnt_branch) * SW'(S_MEM_ACCESS)
		    + SW'(cnt_stack) * SW'(S_MEM_ACCESS)
		    + SW'(cnt_byte) * SW'(s_byte)
		    + SW'(cnt_word) * SW'(S_MEM_ACCESS)
		    + SW'(cnt_internal) * SW'(S_INTERNAL);
	end
	assign states = sum;
endmodule

/* rtl/ocdst_decode.sv */
// Opcode decode front end with registered class and state total.
// Assumes instruction word and cycle counts are synchronous to sys_clk.
module ocdst_decode
	import ocdst_pkg::*;
(
	input  wire logic                           sys_clk,
	input  wire logic                           rst_b,
	input  wire logic                           word_valid,
	input  wire logic [15:0]                    instr_word,
	input  wire logic [ocdst_pkg::CNT_W-1:0]   cnt_fetch,
	input  wire logic [ocdst_pkg::CNT_W-1:0]   cnt_branch,
	input  wire logic [ocdst_pkg::CNT_W-1:0]   cnt_stack,
	input  wire logic [ocdst_pkg::CNT_W-1:0]   cnt_byte,
	input  wire logic [ocdst_pkg::CNT_W-1:0]   cnt_word,
	input  wire logic [ocdst_pkg::CNT_W-1:0]   cnt_internal,
	input  wire logic                           byte_periph,
	input  wire logic                           periph_slow,
	output logic                                dec_valid,
	output ocdst_pkg::ocdst_class_t             op_class,
	output logic                                second_pick,
	output logic [7:0]                          opcode,
	output logic [ocdst_pkg::STATE_W-1:0]      exec_states
);
	import ocdst_pkg::*;

	logic [7:0]          op_byte;
	logic [3:0]          hi_nib;
	logic [3:0]          lo_nib;
	logic                sel;
	ocdst_class_t        cls_d;
	ocdst_class_t        cls_q;
	logic                valid_q;
	logic                sel_q;
	logic [7:0]          opcode_q;
	logic [STATE_W-1:0]  states_d;
	logic [STATE_W-1:0]  states_q;

	assign op_byte = instr_word[OP_HI_BIT:OP_LO_BIT];
	assign hi_nib  = op_byte[7:4];
	assign lo_nib  = op_byte[3:0];
	assign sel     = instr_word[SEL_BIT];

	// Dual-entry cells resolve to one class here; sel is exported for the operand stage
	always_comb begin
		cls_d = OCD_UNDEF;
		unique case (hi_nib)
			4'h0: begin
				unique case (lo_nib)
					4'h0: cls_d = OCD_NOP;
					4'h1: cls_d = OCD_SLEEP;
					4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: cls_d = OCD_CTRL_REG;
					4'h8, 4'h9: cls_d = OCD_ADD;
					4'hA: cls_d = OCD_INCDEC;
					4'hB: cls_d = OCD_ADD;
					// push and pop share move codes
					4'hC, 4'hD: cls_d = OCD_DATA_TRANSFER_OP;
					4'hE: cls_d = OCD_ADDX;
					4'hF: cls_d = OCD_ADJ;
				endcase
			end
			4'h1: begin
				unique case (lo_nib)
					4'h0, 4'h1: cls_d = OCD_SHIFT;
					4'h2, 4'h3: cls_d = OCD_ROTATE;
					4'h4, 4'h5, 4'h6: cls_d = OCD_LOGIC;
					4'h7: cls_d = OCD_UNARY;
					4'h8, 4'h9, 4'hB: cls_d = OCD_SUB;
					4'hA: cls_d = OCD_INCDEC;
					4'hC, 4'hD: cls_d = OCD_CMP;
					4'hE: cls_d = OCD_SUBX;
					4'hF: cls_d = OCD_ADJ;
				endcase
			end
			4'h2, 4'h3: cls_d = OCD_DATA_TRANSFER_OP;
			4'h4: cls_d = OCD_BRANCH;
			4'h5: begin
				unique case (lo_nib)
					4'h0, 4'h1: cls_d = OCD_MULDIV;
					4'h4, 4'h6: cls_d = OCD_RETURN;
					4'h5, 4'hC, 4'hD, 4'hE, 4'hF: cls_d = OCD_CALL;
					4'h9, 4'hA, 4'hB: cls_d = OCD_JUMP;
					default: cls_d = OCD_UNDEF;
				endcase
			end
			4'h6, 4'h7: begin
				if (lo_nib >= 4'h8 && lo_nib <= 4'hA && hi_nib == 4'h6)
					cls_d = OCD_DATA_TRANSFER_OP;
				else if (hi_nib == 4'h7 && lo_nib == 4'hB)
					cls_d = OCD_BLOCK_MOVE;
				else if (hi_nib == 4'h6 && lo_nib >= 4'hB)
					cls_d = OCD_DATA_TRANSFER_OP;
				else if (lo_nib <= 4'h7 || lo_nib >= 4'hC)
					cls_d = OCD_BIT;
				else
					cls_d = OCD_UNDEF;
			end
			4'h8: cls_d = OCD_ADD;
			4'h9: cls_d = OCD_ADDX;
			4'hA: cls_d = OCD_CMP;
			4'hB: cls_d = OCD_SUBX;
			4'hC, 4'hD, 4'hE: cls_d = OCD_LOGIC;
			4'hF: cls_d = OCD_DATA_TRANSFER_OP;
		endcase
	end

	ocdst_state_sum #(
		.CW(CNT_W),
		.SW(STATE_W)
	) u_sum (
		.cnt_fetch    (cnt_fetch),
		.cnt_branch   (cnt_branch),
		.cnt_stack    (cnt_stack),
		.cnt_byte     (cnt_byte),
		.cnt_word     (cnt_word),
		.cnt_internal (cnt_internal),
		.byte_periph  (byte_periph),
		.periph_slow  (periph_slow),
		.states       (states_d)
	);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			valid_q <= 1'b0;
		end else begin
			valid_q <= word_valid;
		end
	end

	// Held between words so the operand stage may read them late
	// bit 7 zero first entry; bit 7 one second entry
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cls_q    <= CLASS_RESET;
			sel_q    <= SEL_RESET;
			opcode_q <= OP_RESET;
		end else if (word_valid) begin
			cls_q    <= cls_d;
			sel_q    <= sel;
			opcode_q <= op_byte;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			states_q <= STATES_RESET;
		end else if (word_valid) begin
			states_q <= states_d;
		end
	end

	assign dec_valid   = valid_q;
	assign op_class    = cls_q;
	assign second_pick = sel_q;
	assign opcode      = opcode_q;
	assign exec_states = states_q;

	a_opcode_byte: assert property (@(posedge sys_clk) disable iff (!rst_b)
		word_valid |=> opcode == $past(instr_word[15:8]))
		else $error("opcode not upper byte");
	a_sel_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
		word_valid && !instr_word[7] |=> !second_pick)
		else $error("bit7 zero gave second entry");
	a_sel_one: assert property (@(posedge sys_clk) disable iff (!rst_b)
		word_valid && instr_word[7] |=> second_pick)
		else $error("bit7 one gave first entry");
	a_push_as_move: assert property (@(posedge sys_clk) disable iff (!rst_b)
		word_valid && instr_word[15:12] == 4'hF |=> op_class == OCD_DATA_TRANSFER_OP)
		else $error("move code not decoded as move");
	sequence s_fetch_only;
		word_valid && cnt_branch == 0 && cnt_stack == 0 && cnt_byte == 0
			&& cnt_word == 0 && cnt_internal == 0;
	endsequence
	a_fetch_cost: assert property (@(posedge sys_clk) disable iff (!rst_b)
		s_fetch_only |=> exec_states == 12'(2 * $past(cnt_fetch)))
		else $error("fetch cost wrong");
	a_internal_cost: assert property (@(posedge sys_clk) disable iff (!rst_b)
		word_valid && cnt_fetch == 0 && cnt_branch == 0 && cnt_stack == 0
		&& cnt_byte == 0 && cnt_word == 0 |=> exec_states == 12'($past(cnt_internal)))
		else $error("internal cost wrong");
	a_periph_slow: assert property (@(posedge sys_clk) disable iff (!rst_b)
		word_valid && byte_periph && periph_slow && cnt_byte == 1 && cnt_fetch == 0
		&& cnt_branch == 0 && cnt_stack == 0 && cnt_word == 0 && cnt_internal == 0
		|=> exec_states == 12'h003)
		else $error("slow peripheral byte not three");
	a_states_sum: assert property (@(posedge sys_clk) disable iff (!rst_b)
		word_valid && !byte_periph |=> exec_states == 12'(2 * ($past(cnt_fetch)
		+ $past(cnt_branch) + $past(cnt_stack) + $past(cnt_byte) + $past(cnt_word))
		+ $past(cnt_internal)))
		else $error("state sum wrong");
	a_states_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!word_valid |=> $stable(exec_states) && $stable(op_class))
		else $error("outputs moved without word");
	a_pick_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!word_valid |=> $stable(second_pick) && $stable(opcode))
		else $error("pick or opcode moved without word");
	// One pulse per taken word; no stretching
	a_valid_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
		word_valid |=> dec_valid)
		else $error("decode valid missing");
	a_valid_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!word_valid |=> !dec_valid)
		else $error("decode valid without word");
	a_row_branch: assert property (@(posedge sys_clk) disable iff (!rst_b)
		word_valid && instr_word[15:12] == 4'h4 |=> op_class == OCD_BRANCH)
		else $error("branch row misdecoded");
	a_block_move: assert property (@(posedge sys_clk) disable iff (!rst_b)
		word_valid && instr_word[15:8] == 8'h7B |=> op_class == OCD_BLOCK_MOVE)
		else $error("block move cell misdecoded");
	a_move_rows: assert property (@(posedge sys_clk) disable iff (!rst_b)
		word_valid && instr_word[15:13] == 3'h1 |=> op_class == OCD_DATA_TRANSFER_OP)
		else $error("move rows misdecoded");
	sequence s_byte_only;
		word_valid && cnt_byte == 1 && cnt_fetch == 0 && cnt_branch == 0
			&& cnt_stack == 0 && cnt_word == 0 && cnt_internal == 0;
	endsequence
	a_periph_fast: assert property (@(posedge sys_clk) disable iff (!rst_b)
		s_byte_only ##0 (byte_periph && !periph_slow) |=> exec_states == 12'h002)
		else $error("fast peripheral byte not two");
	a_mem_byte: assert property (@(posedge sys_clk) disable iff (!rst_b)
		s_byte_only ##0 !byte_periph |=> exec_states == 12'h002)
		else $error("memory byte not two");
endmodule

/* dv/ocdst_periph_model.sv */
// Partner model: cost class of the module behind a byte access.
// Assumes the bench picks the module; no clock needed.
module ocdst_periph_model (
	input  wire logic [1:0] mod_sel,
	output logic            byte_periph,
	output logic            periph_slow
);
	timeunit 1ns;
	timeprecision 1ns;
	assign byte_periph = (mod_sel != 2'h0);
	// fixed per module, slow only at mod_sel two
	assign periph_slow = (mod_sel == 2'h2);
endmodule

/* dv/cpu_opcode_decode_and_state_timing_test.sv */
// Self-checking bench for the opcode decoder and state total.
// Assumes one 10 MHz clock; inputs change on the falling edge.
module cpu_opcode_decode_and_state_timing_test import ocdst_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic         sys_clk = 1'b0;
	logic         rst_b = 1'b0;
	logic         word_valid = 1'b0;
	logic [15:0]  instr_word = 16'h0000;
	logic [7:0]   cf = 8'h00, cb = 8'h00, cs = 8'h00, cy = 8'h00, cw = 8'h00, ci = 8'h00;
	logic [1:0]   mod_sel = 2'h0;
	logic         byte_periph, periph_slow, dec_valid, second_pick;
	ocdst_class_t op_class;
	logic [7:0]   opcode;
	logic [11:0]  exec_states;
	int           fails = 0;
	int           tests_run = 0;
	logic [15:0]  tw[35] = '{16'h0000, 16'h0100, 16'h0880, 16'h0e00, 16'h1800, 16'h1c00,
		16'h1e00, 16'h4700, 16'h8312, 16'h9a00, 16'ha0ff, 16'hb400, 16'h0d80, 16'h2c00,
		16'h3f80, 16'hff00, 16'h1100, 16'h1180, 16'h1700, 16'h1780, 16'hc500, 16'he100,
		16'h0200, 16'h0a00, 16'h0f00, 16'h1280, 16'h5100, 16'h5400, 16'h5e00, 16'h5a00,
		16'h7080, 16'h7b5c, 16'h5700, 16'h6df0, 16'h7900};
	ocdst_class_t tc[35] = '{OCD_NOP, OCD_SLEEP, OCD_ADD, OCD_ADDX, OCD_SUB, OCD_CMP,
		OCD_SUBX, OCD_BRANCH, OCD_ADD, OCD_ADDX, OCD_CMP, OCD_SUBX, OCD_DATA_TRANSFER_OP,
		OCD_DATA_TRANSFER_OP, OCD_DATA_TRANSFER_OP, OCD_DATA_TRANSFER_OP, OCD_SHIFT,
		OCD_SHIFT, OCD_UNARY, OCD_UNARY, OCD_LOGIC, OCD_LOGIC,
		OCD_CTRL_REG, OCD_INCDEC, OCD_ADJ, OCD_ROTATE, OCD_MULDIV, OCD_RETURN, OCD_CALL,
		OCD_JUMP, OCD_BIT, OCD_BLOCK_MOVE, OCD_UNDEF, OCD_DATA_TRANSFER_OP, OCD_UNDEF};
	logic [47:0]  sc[10] = '{48'h0200_0002_0000, 48'h0201_0100_0000, 48'h0103_0507_0b0d,
		48'h0103_0507_0b0d, 48'h0103_0507_0b0d, 48'hffff_ffff_ffff, 48'h0000_0001_0000,
		48'h0000_0001_0000, 48'h0000_0001_0000, 48'h0000_0000_0009};
	logic [1:0]   sm[10] = '{2'h1, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h3, 2'h2, 2'h0};

	ocdst_decode i_ocdst_decode (.sys_clk(sys_clk), .rst_b(rst_b), .word_valid(word_valid),
		.instr_word(instr_word), .cnt_fetch(cf), .cnt_branch(cb), .cnt_stack(cs),
		.cnt_byte(cy), .cnt_word(cw), .cnt_internal(ci), .byte_periph(byte_periph),
		.periph_slow(periph_slow), .dec_valid(dec_valid), .op_class(op_class),
		.second_pick(second_pick), .opcode(opcode), .exec_states(exec_states));
	ocdst_periph_model i_ocdst_periph_model (.mod_sel(mod_sel), .byte_periph(byte_periph),
		.periph_slow(periph_slow));

	always #50 sys_clk = ~sys_clk;

	// Byte cost from the module class, everything else two, internal one
	function automatic logic [11:0] sum(input logic [47:0] c, input logic [1:0] ms);
		logic [11:0] by;
		by = (ms == 2'h2) ? 12'h003 : 12'h002;
		return 12'h002 * (c[47:40] + c[39:32] + c[31:24] + c[15:8]) + by * c[23:16] + c[7:0];
	endfunction

	task automatic end_of_test();
		$display("tests_run %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", nm, exp, got);
			fails++;
		end
	endtask

	task automatic look(input logic [15:0] w, input logic [47:0] c, input logic [1:0] ms,
			input ocdst_class_t cls);
		chk("dec_valid", 16'h0001, {15'h0000, dec_valid});
		chk("opcode", {8'h00, w[15:8]}, {8'h00, opcode});
		chk("second_pick", {15'h0000, w[7]}, {15'h0000, second_pick});
		chk("op_class", {11'h000, cls}, {11'h000, op_class});
		chk("exec_states", {4'h0, sum(c, ms)}, {4'h0, exec_states});
	endtask

	// One word, then valid drops while the word changes underneath
	task automatic run(input logic [15:0] w, input logic [47:0] c, input logic [1:0] ms,
			input ocdst_class_t cls);
		@(negedge sys_clk);
		word_valid = 1'b1;
		instr_word = w;
		{cf, cb, cs, cy, cw, ci} = c;
		mod_sel = ms;
		@(negedge sys_clk);
		word_valid = 1'b0;
		instr_word = ~w;
		look(w, c, ms, cls);
		@(negedge sys_clk);
		chk("dec_valid_drop", 16'h0000, {15'h0000, dec_valid});
		chk("opcode_held", {8'h00, w[15:8]}, {8'h00, opcode});
	endtask

	task automatic b2b();
		@(negedge sys_clk);
		word_valid = 1'b1;
		instr_word = 16'h0c80;
		{cf, cb, cs, cy, cw, ci} = 48'h0100_0000_0000;
		@(negedge sys_clk);
		instr_word = 16'h4000;
		{cf, cb, cs, cy, cw, ci} = 48'h0201_0000_0003;
		look(16'h0c80, 48'h0100_0000_0000, 2'h0, OCD_DATA_TRANSFER_OP);
		@(negedge sys_clk);
		word_valid = 1'b0;
		look(16'h4000, 48'h0201_0000_0003, 2'h0, OCD_BRANCH);
	endtask

	initial begin
		repeat (20) @(negedge sys_clk);
		chk("rst_dec_valid", 16'h0000, {15'h0000, dec_valid});
		chk("rst_states", 16'h0000, {4'h0, exec_states});
		chk("rst_opcode", 16'h0000, {8'h00, opcode});
		chk("rst_second_pick", 16'h0000, {15'h0000, second_pick});
		chk("rst_op_class", {11'h000, OCD_NOP}, {11'h000, op_class});
		rst_b = 1'b1;
		for (int i = 0; i < 35; i++) run(tw[i], 48'h0100_0000_0000, 2'h0, tc[i]);
		for (int i = 0; i < 10; i++) run(16'hf012, sc[i], sm[i], OCD_DATA_TRANSFER_OP);
		b2b();
		end_of_test();
	end

	// Hang guard
	initial begin
		repeat (4000) @(posedge sys_clk);
		fails++;
		end_of_test();
	end
endmodule
